//--- common/psa_map.vh
`ifndef PSA_MAP_VH
`define PSA_MAP_VH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define PSA_DATA_W      64
`define PSA_OP_W        6
`define PSA_RESULT_RST  64'h0000000000000000
`define PSA_EMPTY_RST   1'b1

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define PSA_OP_ADD_BYTES_WRAP           6'h00
`define PSA_OP_ADD_WORDS_WRAP           6'h01
`define PSA_OP_ADD_DWORDS_WRAP          6'h02
`define PSA_OP_ADD_BYTES_SIGNED_SAT     6'h03
`define PSA_OP_ADD_WORDS_SIGNED_SAT     6'h04
`define PSA_OP_ADD_BYTES_UNSIGNED_SAT   6'h05
`define PSA_OP_ADD_WORDS_UNSIGNED_SAT   6'h06
`define PSA_OP_SUB_BYTES_WRAP           6'h08
`define PSA_OP_SUB_WORDS_WRAP           6'h09
`define PSA_OP_SUB_DWORDS_WRAP          6'h0a
`define PSA_OP_SUB_BYTES_SIGNED_SAT     6'h0b
`define PSA_OP_SUB_WORDS_SIGNED_SAT     6'h0c
`define PSA_OP_SUB_BYTES_UNSIGNED_SAT   6'h0d
`define PSA_OP_SUB_WORDS_UNSIGNED_SAT   6'h0e
`define PSA_OP_MUL_WORDS_HIGH           6'h10
`define PSA_OP_MUL_WORDS_LOW            6'h11
`define PSA_OP_MUL_ADD_WORDS            6'h12
`define PSA_OP_CMP_EQ_BYTES             6'h18
`define PSA_OP_CMP_EQ_WORDS             6'h19
`define PSA_OP_CMP_EQ_DWORDS            6'h1a
`define PSA_OP_CMP_GT_BYTES             6'h1b
`define PSA_OP_CMP_GT_WORDS             6'h1c
`define PSA_OP_CMP_GT_DWORDS            6'h1d
`define PSA_OP_AND                      6'h20
`define PSA_OP_AND_NOT                  6'h21
`define PSA_OP_OR                       6'h22
`define PSA_OP_XOR                      6'h23
`define PSA_OP_SHL_WORDS                6'h28
`define PSA_OP_SHL_DWORDS               6'h29
`define PSA_OP_SHL_QUAD                 6'h2a
`define PSA_OP_SHR_WORDS                6'h2b
`define PSA_OP_SHR_DWORDS               6'h2c
`define PSA_OP_SHR_QUAD                 6'h2d
`define PSA_OP_SAR_WORDS                6'h2e
`define PSA_OP_SAR_DWORDS               6'h2f
`define PSA_OP_EMPTY_SIMD_STATE         6'h30
`define PSA_OP_MOVE_DWORD               6'h38
`define PSA_OP_MOVE_QUAD                6'h39

`endif

//--- rtl/psa_lane.v
`default_nettype none

// ----------------------------------------------------------------
// One lane of W bits: add, subtract, compare and shift
// ----------------------------------------------------------------
module psa_lane #(
    parameter W = 8
) (
    input  wire [W-1:0] i_a,
    input  wire [W-1:0] i_b,
    input  wire         i_big,
    input  wire [5:0]   i_shamt,
    output wire [W-1:0] o_add,
    output wire [W-1:0] o_sub,
    output wire [W-1:0] o_add_ss,
    output wire [W-1:0] o_add_us,
    output wire [W-1:0] o_sub_ss,
    output wire [W-1:0] o_sub_us,
    output wire [W-1:0] o_eq,
    output wire [W-1:0] o_gt,
    output wire [W-1:0] o_shl,
    output wire [W-1:0] o_shr,
    output wire [W-1:0] o_sar
);

    localparam [W-1:0] MAX_S = {1'b0, {(W-1){1'b1}}};
    localparam [W-1:0] MIN_S = {1'b1, {(W-1){1'b0}}};

    wire        [W:0]   sum = {1'b0, i_a} + {1'b0, i_b};
    wire        [W:0]   dif = {1'b0, i_a} - {1'b0, i_b};
    wire signed [W-1:0] sa  = i_a;
    wire signed [W-1:0] sb  = i_b;
    wire        [W-1:0] sar_raw = sa >>> i_shamt;
    wire                ovf_add;
    wire                ovf_sub;

    assign ovf_add = (i_a[W-1] == i_b[W-1]) && (sum[W-1] != i_a[W-1]);
    assign ovf_sub = (i_a[W-1] != i_b[W-1]) && (dif[W-1] != i_a[W-1]);

    assign o_add = sum[W-1:0];
    assign o_sub = dif[W-1:0];
    assign o_add_ss = ovf_add ? (i_a[W-1] ? MIN_S : MAX_S)
                              : sum[W-1:0];
    assign o_add_us = sum[W] ? {W{1'b1}} : sum[W-1:0];
    assign o_sub_ss = ovf_sub ? (i_a[W-1] ? MIN_S : MAX_S)
                              : dif[W-1:0];
    assign o_sub_us = dif[W] ? {W{1'b0}} : dif[W-1:0];

    // All-ones on true, all-zeros on false
    assign o_eq = {W{i_a == i_b}};
    assign o_gt = {W{sa > sb}};

    // Counts at or above the lane width saturate the shift
    assign o_shl = i_big ? {W{1'b0}} : (i_a << i_shamt);
    assign o_shr = i_big ? {W{1'b0}} : (i_a >> i_shamt);
    assign o_sar = i_big ? {W{i_a[W-1]}} : sar_raw;

endmodule // psa_lane

`default_nettype wire

//--- rtl/psa_alu.v
`include "psa_map.vh"
`default_nettype none

// How it works
// - 64-bit operands split into byte, word, dword lanes or one quadword.
// - Lane add wraps on overflow, no carry crosses lanes.
// - Signed saturating add clamps byte/word lanes to signed range.
// - Unsigned saturating add clamps byte/word lanes to all ones.
// - Lane subtract wraps, no borrow crosses lanes.
// - Signed saturating subtract clamps byte/word lanes to signed range.
// - Unsigned saturating subtract floors byte/word lanes at zero.
// - Multiply-high keeps upper 16 bits of each signed word product.
// - Multiply-low keeps lower 16 bits of each signed word product.
// - Multiply-add multiplies word lanes and sums the products.
// - Equality compare per byte, word or dword lane.
// - Signed greater-than compare per byte, word or dword lane.
// - AND, AND-NOT, OR, XOR across the whole quadword.
// - Left logical shift of words, dwords or quad, zero fill.
// - Right logical shift of words, dwords or quad, zero fill.
// - Right arithmetic shift for words and dwords, sign fill.
// - Empty-state operation marks packed register state empty.
// - Dword move zero-extends the low dword of source A; quadword move copies source A.
module psa_alu (
    input  wire                   i_mclk,
    input  wire                   i_rstn,
    input  wire                   i_ce,
    input  wire                   i_valid,
    input  wire [`PSA_OP_W-1:0]   i_op,
    input  wire [`PSA_DATA_W-1:0] i_src_a,
    input  wire [`PSA_DATA_W-1:0] i_src_b,
    output reg                    o_valid,
    output reg  [`PSA_DATA_W-1:0] o_result,
    output reg                    o_illegal,
    output reg                    o_simd_empty
);

    // ------------------------------------------------------------
    // Lane result buses
    // ------------------------------------------------------------
    wire [63:0] add_b;
    wire [63:0] sub_b;
    wire [63:0] add_ss_b;
    wire [63:0] add_us_b;
    wire [63:0] sub_ss_b;
    wire [63:0] sub_us_b;
    wire [63:0] eq_b;
    wire [63:0] gt_b;

    wire [63:0] add_w;
    wire [63:0] sub_w;
    wire [63:0] add_ss_w;
    wire [63:0] add_us_w;
    wire [63:0] sub_ss_w;
    wire [63:0] sub_us_w;
    wire [63:0] eq_w;
    wire [63:0] gt_w;
    wire [63:0] shl_w;
    wire [63:0] shr_w;
    wire [63:0] sar_w;

    wire [63:0] add_d;
    wire [63:0] sub_d;
    wire [63:0] eq_d;
    wire [63:0] gt_d;
    wire [63:0] shl_d;
    wire [63:0] shr_d;
    wire [63:0] sar_d;

    wire [127:0] prod;
    wire [63:0]  mul_hi;
    wire [63:0]  mul_lo;
    wire [63:0]  mul_add;

    wire [63:0] shl_q;
    wire [63:0] shr_q;

    // ------------------------------------------------------------
    // Shift count decode
    // ------------------------------------------------------------
    wire       big_w = |i_src_b[63:4];
    wire       big_d = |i_src_b[63:5];
    wire       big_q = |i_src_b[63:6];
    wire [5:0] amt_w = {2'b00, i_src_b[3:0]};
    wire [5:0] amt_d = {1'b0, i_src_b[4:0]};
    wire [5:0] amt_q = i_src_b[5:0];

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb = gb + 1) begin : g_byte
            psa_lane #(
                .W (8)
            ) u_lane (
                .i_a      (i_src_a[8*gb +: 8]),
                .i_b      (i_src_b[8*gb +: 8]),
                .i_big    (1'b0),
                .i_shamt  (6'h00),
                .o_add    (add_b[8*gb +: 8]),
                .o_sub    (sub_b[8*gb +: 8]),
                .o_add_ss (add_ss_b[8*gb +: 8]),
                .o_add_us (add_us_b[8*gb +: 8]),
                .o_sub_ss (sub_ss_b[8*gb +: 8]),
                .o_sub_us (sub_us_b[8*gb +: 8]),
                .o_eq     (eq_b[8*gb +: 8]),
                .o_gt     (gt_b[8*gb +: 8]),
                .o_shl    (),
                .o_shr    (),
                .o_sar    ()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Word lanes with signed multipliers
    // ------------------------------------------------------------
    genvar gw;
    generate
        for (gw = 0; gw < 4; gw = gw + 1) begin : g_word
            wire signed [15:0] ma = i_src_a[16*gw +: 16];
            wire signed [15:0] mb = i_src_b[16*gw +: 16];
            wire signed [31:0] p  = ma * mb;

            assign prod[32*gw +: 32]   = p;
            assign mul_hi[16*gw +: 16] = p[31:16];
            assign mul_lo[16*gw +: 16] = p[15:0];

            psa_lane #(
                .W (16)
            ) u_lane (
                .i_a      (i_src_a[16*gw +: 16]),
                .i_b      (i_src_b[16*gw +: 16]),
                .i_big    (big_w),
                .i_shamt  (amt_w),
                .o_add    (add_w[16*gw +: 16]),
                .o_sub    (sub_w[16*gw +: 16]),
                .o_add_ss (add_ss_w[16*gw +: 16]),
                .o_add_us (add_us_w[16*gw +: 16]),
                .o_sub_ss (sub_ss_w[16*gw +: 16]),
                .o_sub_us (sub_us_w[16*gw +: 16]),
                .o_eq     (eq_w[16*gw +: 16]),
                .o_gt     (gt_w[16*gw +: 16]),
                .o_shl    (shl_w[16*gw +: 16]),
                .o_shr    (shr_w[16*gw +: 16]),
                .o_sar    (sar_w[16*gw +: 16])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Doubleword lanes and multiply-add
    // ------------------------------------------------------------
    genvar gd;
    generate
        for (gd = 0; gd < 2; gd = gd + 1) begin : g_dword
            // Sum of two signed products wraps in 32 bits
            assign mul_add[32*gd +: 32] = prod[64*gd +: 32]
                                        + prod[64*gd+32 +: 32];

            psa_lane #(
                .W (32)
            ) u_lane (
                .i_a      (i_src_a[32*gd +: 32]),
                .i_b      (i_src_b[32*gd +: 32]),
                .i_big    (big_d),
                .i_shamt  (amt_d),
                .o_add    (add_d[32*gd +: 32]),
                .o_sub    (sub_d[32*gd +: 32]),
                .o_add_ss (),
                .o_add_us (),
                .o_sub_ss (),
                .o_sub_us (),
                .o_eq     (eq_d[32*gd +: 32]),
                .o_gt     (gt_d[32*gd +: 32]),
                .o_shl    (shl_d[32*gd +: 32]),
                .o_shr    (shr_d[32*gd +: 32]),
                .o_sar    (sar_d[32*gd +: 32])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Quadword shifts
    // ------------------------------------------------------------
    assign shl_q = big_q ? 64'h0 : (i_src_a << amt_q);
    assign shr_q = big_q ? 64'h0 : (i_src_a >> amt_q);

    // ------------------------------------------------------------
    // Result select
    // ------------------------------------------------------------
    reg [63:0] next_result;
    reg        next_illegal;
    reg        next_empty;

    always @* begin
        next_result  = `PSA_RESULT_RST;
        next_illegal = 1'b0;
        next_empty   = 1'b0;
        case (i_op)
            `PSA_OP_ADD_BYTES_WRAP:
                next_result = add_b;
            `PSA_OP_ADD_WORDS_WRAP:
                next_result = add_w;
            `PSA_OP_ADD_DWORDS_WRAP:
                next_result = add_d;
            `PSA_OP_ADD_BYTES_SIGNED_SAT:
                next_result = add_ss_b;
            `PSA_OP_ADD_WORDS_SIGNED_SAT:
                next_result = add_ss_w;
            `PSA_OP_ADD_BYTES_UNSIGNED_SAT:
                next_result = add_us_b;
            `PSA_OP_ADD_WORDS_UNSIGNED_SAT:
                next_result = add_us_w;
            `PSA_OP_SUB_BYTES_WRAP:
                next_result = sub_b;
            `PSA_OP_SUB_WORDS_WRAP:
                next_result = sub_w;
            `PSA_OP_SUB_DWORDS_WRAP:
                next_result = sub_d;
            `PSA_OP_SUB_BYTES_SIGNED_SAT:
                next_result = sub_ss_b;
            `PSA_OP_SUB_WORDS_SIGNED_SAT:
                next_result = sub_ss_w;
            `PSA_OP_SUB_BYTES_UNSIGNED_SAT:
                next_result = sub_us_b;
            `PSA_OP_SUB_WORDS_UNSIGNED_SAT:
                next_result = sub_us_w;
            `PSA_OP_MUL_WORDS_HIGH:
                next_result = mul_hi;
            `PSA_OP_MUL_WORDS_LOW:
                next_result = mul_lo;
            `PSA_OP_MUL_ADD_WORDS:
                next_result = mul_add;
            `PSA_OP_CMP_EQ_BYTES:
                next_result = eq_b;
            `PSA_OP_CMP_EQ_WORDS:
                next_result = eq_w;
            `PSA_OP_CMP_EQ_DWORDS:
                next_result = eq_d;
            `PSA_OP_CMP_GT_BYTES:
                next_result = gt_b;
            `PSA_OP_CMP_GT_WORDS:
                next_result = gt_w;
            `PSA_OP_CMP_GT_DWORDS:
                next_result = gt_d;
            `PSA_OP_AND:
                next_result = i_src_a & i_src_b;
            `PSA_OP_AND_NOT:
                next_result = ~i_src_a & i_src_b;
            `PSA_OP_OR:
                next_result = i_src_a | i_src_b;
            `PSA_OP_XOR:
                next_result = i_src_a ^ i_src_b;
            `PSA_OP_SHL_WORDS:
                next_result = shl_w;
            `PSA_OP_SHL_DWORDS:
                next_result = shl_d;
            `PSA_OP_SHL_QUAD:
                next_result = shl_q;
            `PSA_OP_SHR_WORDS:
                next_result = shr_w;
            `PSA_OP_SHR_DWORDS:
                next_result = shr_d;
            `PSA_OP_SHR_QUAD:
                next_result = shr_q;
            `PSA_OP_SAR_WORDS:
                next_result = sar_w;
            `PSA_OP_SAR_DWORDS:
                next_result = sar_d;
            `PSA_OP_EMPTY_SIMD_STATE:
                next_empty = 1'b1;
            `PSA_OP_MOVE_DWORD:
                next_result = {32'h0, i_src_a[31:0]};
            `PSA_OP_MOVE_QUAD:
                next_result = i_src_a;
            default:
                next_illegal = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Output stage and empty-state flag
    // ------------------------------------------------------------
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid      <= 1'b0;
            o_result     <= `PSA_RESULT_RST;
            o_illegal    <= 1'b0;
            o_simd_empty <= `PSA_EMPTY_RST;
        end else if (i_ce) begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_result  <= next_result;
                o_illegal <= next_illegal;
                // Any legal op except the empty-state op marks the state in use; that op marks it empty
                if (!next_illegal) begin
                    o_simd_empty <= next_empty;
                end
            end else begin
                o_illegal <= 1'b0;
            end
        end
    end

endmodule // psa_alu

`default_nettype wire

//--- bench/psa_alu_monitor.sv
`include "psa_map.vh"
`default_nettype none

module psa_alu_monitor (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_ce,
    input wire logic        i_valid,
    input wire logic [5:0]  i_op,
    input wire logic [63:0] i_src_a,
    input wire logic [63:0] i_src_b,
    input wire logic        o_valid,
    input wire logic [63:0] o_result,
    input wire logic        o_illegal,
    input wire logic        o_simd_empty
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    wire logic take;
    assign take = i_ce && i_valid;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_take;
        take |=> o_valid;
    endproperty
    a_take: assert property (p_take)
        else $error("result valid missing");
    property p_idle;
        i_ce && !i_valid |=> !o_valid && $stable(o_result);
    endproperty
    a_idle: assert property (p_idle)
        else $error("spurious result");
    property p_freeze;
        !i_ce |=> $stable(o_valid) && $stable(o_result)
            && $stable(o_simd_empty);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("outputs moved while disabled");
    property p_add_w;
        take && i_op == `PSA_OP_ADD_WORDS_WRAP |=>
            o_result[15:0] == $past(i_src_a[15:0]) + $past(i_src_b[15:0]);
    endproperty
    a_add_w: assert property (p_add_w)
        else $error("word add wrong");
    property p_sub_us;
        take && i_op == `PSA_OP_SUB_BYTES_UNSIGNED_SAT |=> o_result[7:0] ==
            ($past(i_src_a[7:0]) < $past(i_src_b[7:0]) ? 8'h00 :
             $past(i_src_a[7:0]) - $past(i_src_b[7:0]));
    endproperty
    a_sub_us: assert property (p_sub_us)
        else $error("unsigned sat subtract wrong");
    property p_mul_lo;
        take && i_op == `PSA_OP_MUL_WORDS_LOW |=>
            o_result[15:0] == $past(i_src_a[15:0]) * $past(i_src_b[15:0]);
    endproperty
    a_mul_lo: assert property (p_mul_lo)
        else $error("multiply low wrong");
    property p_cmp_eq;
        take && i_op == `PSA_OP_CMP_EQ_DWORDS |=> o_result[31:0] ==
            ($past(i_src_a[31:0]) == $past(i_src_b[31:0]) ?
             32'hffffffff : 32'h00000000);
    endproperty
    a_cmp_eq: assert property (p_cmp_eq)
        else $error("compare mask wrong");
    property p_xor;
        take && i_op == `PSA_OP_XOR |=>
            o_result == ($past(i_src_a) ^ $past(i_src_b));
    endproperty
    a_xor: assert property (p_xor)
        else $error("xor wrong");
    property p_empty;
        take && i_op == `PSA_OP_EMPTY_SIMD_STATE |=>
            o_simd_empty && o_result == 64'h0;
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty state not set");
    property p_move;
        take && i_op == `PSA_OP_MOVE_DWORD |=>
            o_result == {32'h0, $past(i_src_a[31:0])};
    endproperty
    a_move: assert property (p_move)
        else $error("dword move wrong");

    c_empty: cover property (take && i_op == `PSA_OP_EMPTY_SIMD_STATE);
    c_freeze: cover property (!i_ce && o_valid);
    c_illegal: cover property (o_illegal);
endmodule // psa_alu_monitor

bind psa_alu psa_alu_monitor u_mon (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_ce(i_ce), .i_valid(i_valid), .i_op(i_op), .i_src_a(i_src_a),
    .i_src_b(i_src_b), .o_valid(o_valid), .o_result(o_result),
    .o_illegal(o_illegal), .o_simd_empty(o_simd_empty));

`default_nettype wire

//--- bench/psa_regfile_model.sv
`default_nettype none

// ----------------------------------------------------------------
// Write-back side: counts and keeps legal results
// ----------------------------------------------------------------
module psa_regfile_model (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_ce,
    input wire logic        i_wb_valid,
    input wire logic        i_wb_illegal,
    input wire logic [63:0] i_wb_data,
    output var logic [63:0] o_last,
    output var logic [31:0] o_wb_count
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_last     <= 64'h0;
            o_wb_count <= 32'h0;
        end else if (i_ce && i_wb_valid && !i_wb_illegal) begin
            o_last     <= i_wb_data;
            o_wb_count <= o_wb_count + 32'h1;
        end
    end
endmodule // psa_regfile_model

`default_nettype wire

//--- bench/packed_integer_simd_alu_tb.sv
`include "psa_map.vh"
`default_nettype none

`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        err_count++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
end

module packed_integer_simd_alu_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_mclk, i_rstn, i_ce, i_valid;
    logic [5:0]  i_op;
    logic [63:0] i_src_a, i_src_b, exp_r, last_wb, a, b;
    wire logic   o_valid, o_illegal, o_simd_empty;
    wire logic [63:0] o_result, wb_last;
    wire logic [31:0] wb_count;
    logic        exp_v, exp_i, exp_e;
    int          err_count, tests_run, n_wb;
    logic [63:0] pa [4] = '{64'h7f80ff017fff8000, 64'h8000800080008000,
                            64'h00000000ffffffff, 64'h800000007fffffff};
    logic [63:0] pb [4] = '{64'h0180010200018000, 64'h8000800080008000,
                            64'h00000000ffffffff, 64'h00000001ffffffff};

    psa_alu u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_valid(i_valid), .i_op(i_op), .i_src_a(i_src_a),
        .i_src_b(i_src_b), .o_valid(o_valid), .o_result(o_result),
        .o_illegal(o_illegal), .o_simd_empty(o_simd_empty));
    psa_regfile_model u_rf (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_wb_valid(o_valid), .i_wb_illegal(o_illegal),
        .i_wb_data(o_result), .o_last(wb_last), .o_wb_count(wb_count));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic longint sx(logic [63:0] v, int w);
        return longint'(v << (64 - w)) >>> (64 - w);
    endfunction

    function automatic longint sat(longint s, longint hi);
        return s > hi ? hi : (s < -hi - 1 ? -hi - 1 : s);
    endfunction

    function automatic void decode(input logic [5:0] op, output int k, w);
        k = -1;
        w = 16;
        case (op)
            6'h00, 6'h01, 6'h02: begin k = 0; w = 8 << op; end
            6'h03, 6'h04: begin k = 1; w = 8 << (op - 3); end
            6'h05, 6'h06: begin k = 2; w = 8 << (op - 5); end
            6'h08, 6'h09, 6'h0a: begin k = 3; w = 8 << (op - 8); end
            6'h0b, 6'h0c: begin k = 4; w = 8 << (op - 11); end
            6'h0d, 6'h0e: begin k = 5; w = 8 << (op - 13); end
            6'h10, 6'h11, 6'h12: k = op - 5;
            6'h18, 6'h19, 6'h1a: begin k = 6; w = 8 << (op - 24); end
            6'h1b, 6'h1c, 6'h1d: begin k = 7; w = 8 << (op - 27); end
            6'h20, 6'h21, 6'h22, 6'h23: k = op - 18;
            6'h28, 6'h29, 6'h2a: begin k = 8; w = 16 << (op - 40); end
            6'h2b, 6'h2c, 6'h2d: begin k = 9; w = 16 << (op - 43); end
            6'h2e, 6'h2f: begin k = 10; w = 16 << (op - 46); end
            6'h30: k = 18;
            6'h38, 6'h39: k = op - 37;
            default: k = -1;
        endcase
    endfunction

    function automatic logic [63:0] ref_res(int k, w, logic [63:0] a, b);
        logic [63:0] r, m, ua, ub, v;
        longint      sa, sb, hi;
        r = '0;
        m = w == 64 ? '1 : (64'h1 << w) - 1;
        hi = longint'(m >> 1);
        case (k)
            13: for (int i = 0; i < 2; i++) begin
                sa = sx(a >> (32 * i), 16) * sx(b >> (32 * i), 16);
                sb = sx(a >> (32 * i + 16), 16) * sx(b >> (32 * i + 16), 16);
                r[32 * i +: 32] = 32'(sa + sb);
            end
            14: r = a & b;
            15: r = ~a & b;
            16: r = a | b;
            17: r = a ^ b;
            19: r = {32'h0, a[31:0]};
            20: r = a;
            default: if (k >= 0 && k <= 12) begin
                for (int i = 0; i < 64 / w; i++) begin
                    ua = (a >> (i * w)) & m;
                    ub = (b >> (i * w)) & m;
                    sa = sx(ua, w);
                    sb = sx(ub, w);
                    case (k)
                        0: v = ua + ub;
                        1: v = sat(sa + sb, hi);
                        2: v = ua + ub > m ? m : ua + ub;
                        3: v = ua - ub;
                        4: v = sat(sa - sb, hi);
                        5: v = ua < ub ? '0 : ua - ub;
                        6: v = ua == ub ? m : '0;
                        7: v = sa > sb ? m : '0;
                        8: v = b >= w ? '0 : ua << b;
                        9: v = b >= w ? '0 : ua >> b;
                        10: v = b >= w ? (sa < 0 ? m : '0) : sa >>> b;
                        11: v = (sa * sb) >>> 16;
                        default: v = sa * sb;
                    endcase
                    r = r | ((v & m) << (i * w));
                end
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Driver: checks the previous result, then presents a request
    // ------------------------------------------------------------
    task automatic step(input logic v, ce, input logic [5:0] op,
                        input logic [63:0] a, b);
        int k, w;
        @(negedge i_mclk);
        `CHK("o_valid", exp_v, o_valid)
        `CHK("o_illegal", exp_i, o_illegal)
        `CHK("o_simd_empty", exp_e, o_simd_empty)
        `CHK("o_result", exp_r, o_result)
        i_valid = v;
        i_ce = ce;
        i_op = op;
        i_src_a = a;
        i_src_b = b;
        decode(op, k, w);
        if (ce) begin
            exp_v = v;
            exp_i = v && k < 0;
            if (v) begin
                exp_r = ref_res(k, w, a, b);
                if (k >= 0) begin
                    exp_e = k == 18;
                    n_wb++;
                    last_wb = exp_r;
                end
            end
        end
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // Run-length limit
    initial begin
        repeat (100000) @(posedge i_mclk);
        err_count++;
        close_out;
    end

    initial begin
        {i_rstn, i_valid, i_op, i_src_a, i_src_b} = '0;
        i_ce = 1'b1;
        {exp_v, exp_i, exp_r, n_wb, last_wb} = '0;
        exp_e = 1'b1;
        err_count = 0;
        tests_run = 0;
        void'($urandom(8527));
        repeat (10) @(negedge i_mclk);
        i_rstn = 1'b1;
        for (int r = 0; r < 24; r++) begin
            a = r < 4 ? pa[r] : {$urandom, $urandom};
            b = r < 4 ? pb[r] : {$urandom, $urandom};
            for (int op = 0; op < 64; op++) begin
                if (op >= 40 && op < 48 && r[0])
                    step(1, 1, 6'(op), a, 64'($urandom_range(0, 70)));
                else if (op >= 40 && op < 48 && r[2:1] != 0)
                    step(1, 1, 6'(op), a, 64'(r[2:1]) << 4);
                else
                    step(1, 1, 6'(op), a, b);
            end
        end
        // Clock enable low freezes a standing result
        step(1, 1, `PSA_OP_ADD_BYTES_WRAP, a, b);
        step(1, 0, `PSA_OP_XOR, b, a);
        step(1, 0, `PSA_OP_EMPTY_SIMD_STATE, a, b);
        step(0, 1, 6'h00, a, b);
        // Reset in mid-run
        @(negedge i_mclk);
        i_rstn = 1'b0;
        {exp_v, exp_i, exp_r, n_wb, last_wb} = '0;
        exp_e = 1'b1;
        step(0, 1, 6'h00, '0, '0);
        i_rstn = 1'b1;
        step(1, 1, `PSA_OP_MOVE_QUAD, a, b);
        step(0, 1, 6'h00, a, b);
        step(0, 1, 6'h00, a, b);
        `CHK("wb_count", 32'(n_wb), wb_count)
        `CHK("wb_last", last_wb, wb_last)
        close_out;
    end
endmodule // packed_integer_simd_alu_tb

`default_nettype wire
